// File: verilog/mode_select_consts.svh
// Purpose: Constants for the mode select instruction decoder
// Assumes: 16-bit instruction words, 32-bit APB registers
// Notes: Offsets are byte addresses (index times four)
`ifndef MODE_SELECT_CONSTS_SVH
`define MODE_SELECT_CONSTS_SVH

// Register indexes as printed
`define IDX_DRIVE_A 12'h184
`define IDX_DRIVE_B 12'h185
`define IDX_DRIVE_C 12'h186
`define IDX_DRIVE_D 12'h187
`define IDX_CUR_FIRST 12'h188
`define IDX_CUR_SECOND 12'h189
// Own registers
`define IDX_CORE_SETUP 12'h190
`define IDX_MODE_STATUS 12'h191

// Opcode patterns (upper bits compared under mask)
`define OPC_SHRSI 16'h2780
`define MSK_SHRSI 16'hff80
`define OPC_SLAB 16'h360a
`define MSK_SLAB 16'hfffe
`define OPC_SLFBK 16'h3640
`define MSK_SLFBK 16'hfff8
`define OPC_SLSA 16'h3608
`define MSK_SLSA 16'hfffe
`define OPC_STAB 16'h3400
`define MSK_STAB 16'hffc0
`define OPC_STADC 16'h3568
`define MSK_STADC 16'hfff8
`define OPC_STAL 16'h357c
`define MSK_STAL 16'hfffc

// Reset values
`define RST_ARITH_MODE 2'h2
`define RST_BASE_SRC 1'h0
`define RST_SPI_SRC 1'h0
`define RST_FB_REF 1'h0
`define RST_AUTO_DIAG 1'h0

// Diagnosis codes
`define DIAG_KEEP 2'h0
`define DIAG_OFF 2'h2
`define DIAG_ON 2'h3

// Arithmetic mode bits
`define ARITH_UNSIGNED_BIT 1
`define ARITH_SAT_BIT 0

`endif

// File: verilog/mode_select_pkg.sv
// Purpose: Types for the mode select instruction decoder
// Assumes: Consts header supplies numbers
// Notes: Types only
`default_nettype none
package mode_select_pkg;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } instr_type;

  typedef struct packed {
    logic base_from_index;
    logic spi_from_index;
    logic [5:0] base_value;
    logic fb_ref_battery;
    logic auto_diag_on;
    logic [3:0] adc_mode;
    logic [1:0] arith_mode;
  } settings_type;

  typedef struct packed {
    logic shift_out_flag;
    logic shift_overflow_flag;
  } cond_type;

  typedef enum logic [1:0] {
    st_idle,
    st_shift,
    st_finish
  } exec_state_type;
endpackage
`default_nettype wire

// File: verilog/mode_select_decoder.sv
// Purpose: Decode and execute shift and mode select instructions of one microcore
// Assumes: One instruction at a time; issue only while ready is high
// Notes: Rights registers reached over APB; settings exported as flops
//
// Register access over APB was decided locally.
`include "mode_select_consts.svh"
`default_nettype none

// Notes on behaviour
// [RL1] The signed right shift keeps the sign bit and shifts the rest right as two's complement.
// [RL2] The signed right shift takes one clock per count of its 4-bit immediate.
// [RL3] After the signed right shift the shift-out and shift-overflow flags are updated.
// [RL4] The base source instruction picks the dedicated base for 0 and the index register for 1, dedicated at reset.
// [RL5] The feedback reference goes to boost for 0 and battery for 1, boost at reset.
// [RL6] Diagnosis code 00 keeps, 10 disables, 11 enables automatic diagnosis, and 01 does nothing.
// [RL7] The feedback reference instruction acts only with drive rights from the output rights registers.
// [RL8] The SPI pointer instruction picks the dedicated SPI address for 0 and the index register for 1.
// [RL9] The load base instruction writes its 6-bit immediate into the base register.
// [RL10] The conversion mode instruction sets conversion for 1 and comparison for 0, comparison at reset.
// [RL11] The 2-bit target picks same/other core and same/other channel blocks.
// [RL12] The conversion mode instruction acts only with access rights from the current block rights registers.
// [RL13] The arithmetic mode instruction stores its 2-bit operand as the ALU mode bits.
// [RL14] Overflow is flagged in all modes and clamping happens only in saturating modes; the code registers the overflow input but exports no flag.
// [RL15] After reset the arithmetic mode is unsigned without saturation.
// [RL16] Without rights the guarded instructions change nothing and still complete.
module mode_select_decoder #(
  parameter int DATA_W = 16,
  parameter int CORE_BIT = 0,
  parameter int CHAN_BIT = 1,
  parameter int DRIVE_BIT = 0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction issue
  input wire mode_select_pkg::instr_type instr,
  input wire logic [2:0] alu_reg_select,
  input wire logic [DATA_W-1:0] alu_operand,
  output logic instr_ready,
  output logic instr_done,
  output logic [DATA_W-1:0] shift_result,
  // ALU overflow report from arithmetic path
  input wire logic arith_overflow_in,
  // Settings and flags
  output mode_select_pkg::settings_type settings,
  output mode_select_pkg::cond_type cond_flags,
  output logic saturate_enable,
  output logic [DATA_W-1:0] alu_index_value_mux
);
  import mode_select_pkg::*;

  // Rights and setup registers
  logic [15:0] drive_rights_q [4];
  logic [15:0] cur_rights_q [2];
  logic [DATA_W-1:0] index_reg_q;
  exec_state_type state_q;
  logic [3:0] count_q;
  logic [DATA_W-1:0] work_q;
  logic sb_acc_q;
  logic mo_acc_q;
  settings_type settings_q;
  cond_type cond_q;
  logic done_q;
  logic arith_ovf_q;

  // Opcode match helper
  function automatic logic hit(input logic [15:0] w, input logic [15:0] opc, input logic [15:0] msk);
    hit = (w & msk) == opc;
  endfunction

  // Word index from byte address; low two bits ignored
  wire logic [11:0] word_idx = paddr[13:2];
  wire logic apb_access = psel && penable;
  wire logic apb_wr = apb_access && pwrite;
  wire logic idx_drive = word_idx >= `IDX_DRIVE_A && word_idx <= `IDX_DRIVE_D;
  wire logic idx_cur = word_idx == `IDX_CUR_FIRST || word_idx == `IDX_CUR_SECOND;
  wire logic idx_setup = word_idx == `IDX_CORE_SETUP;
  wire logic idx_status = word_idx == `IDX_MODE_STATUS;
  wire logic idx_mapped = idx_drive || idx_cur || idx_setup || idx_status;
  wire logic [1:0] drive_sel = word_idx[1:0];
  wire logic cur_sel = word_idx[0];

  // Instruction decode
  wire logic [15:0] iw = instr.word;
  wire logic issue = instr.valid && state_q == st_idle;
  wire logic do_shrsi = issue && hit(iw, `OPC_SHRSI, `MSK_SHRSI);
  wire logic do_slab = issue && hit(iw, `OPC_SLAB, `MSK_SLAB);
  wire logic do_slfbk = issue && hit(iw, `OPC_SLFBK, `MSK_SLFBK);
  wire logic do_slsa = issue && hit(iw, `OPC_SLSA, `MSK_SLSA);
  wire logic do_stab = issue && hit(iw, `OPC_STAB, `MSK_STAB);
  wire logic do_stadc = issue && hit(iw, `OPC_STADC, `MSK_STADC);
  wire logic do_stal = issue && hit(iw, `OPC_STAL, `MSK_STAL);
  wire logic [3:0] shift_imm = iw[6:3];

  // Drive right: any of the four rights words grants this core's bit
  wire logic drive_ok = drive_rights_q[0][DRIVE_BIT] | drive_rights_q[1][DRIVE_BIT] |
                        drive_rights_q[2][DRIVE_BIT] | drive_rights_q[3][DRIVE_BIT]; // [RL7]
  // Target block number: bit0 other core, bit1 other channel
  wire logic [1:0] target_sel = iw[1:0]; // [RL11]
  wire logic [1:0] own_block = {CHAN_BIT[0], CORE_BIT[0]};
  wire logic [1:0] block_num = own_block ^ {target_sel[1], target_sel[0]}; // [RL11]
  wire logic cur_ok = cur_rights_q[0][block_num] | cur_rights_q[1][block_num]; // [RL12]

  // Shift step: sign kept, lsb falls out
  wire logic [DATA_W-1:0] shift_step = {work_q[DATA_W-1], work_q[DATA_W-1:1]}; // [RL1]

  // APB register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        drive_rights_q[i] <= 16'h0000;
      end
      cur_rights_q[0] <= 16'h0000;
      cur_rights_q[1] <= 16'h0000;
      index_reg_q <= '0;
    end else if (apb_wr) begin
      if (idx_drive) begin
        drive_rights_q[drive_sel] <= pwdata[15:0];
      end
      if (idx_cur) begin
        cur_rights_q[cur_sel] <= pwdata[15:0];
      end
      if (idx_setup) begin
        index_reg_q <= pwdata[DATA_W-1:0];
      end
    end
  end

  // Read mux; unmapped words read zero with an error
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx_drive) begin
      rd_mux = {16'h0000, drive_rights_q[drive_sel]};
    end else if (idx_cur) begin
      rd_mux = {16'h0000, cur_rights_q[cur_sel]};
    end else if (idx_setup) begin
      rd_mux = {{(32 - DATA_W){1'b0}}, index_reg_q};
    end else if (idx_status) begin
      rd_mux = {14'h0000, cond_q, settings_q};
    end
  end

  // APB answer registered: ready in the first access cycle, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rd_mux;
      pslverr <= psel && !penable && !idx_mapped;
    end
  end

  // Shift sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      count_q <= 4'h0;
      work_q <= '0;
      sb_acc_q <= 1'b0;
      mo_acc_q <= 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (do_shrsi) begin
            work_q <= alu_operand;
            count_q <= shift_imm; // [RL2]
            sb_acc_q <= 1'b0;
            mo_acc_q <= 1'b0;
            state_q <= (shift_imm == 4'h0) ? st_finish : st_shift;
          end
        end
        st_shift: begin
          work_q <= shift_step; // [RL1]
          sb_acc_q <= work_q[0];
          mo_acc_q <= mo_acc_q | work_q[0]; // [RL3]
          count_q <= count_q - 4'h1;
          if (count_q == 4'h1) begin
            state_q <= st_finish;
          end
        end
        st_finish: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // Mode settings; guarded ones need rights
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settings_q.base_from_index <= `RST_BASE_SRC; // [RL4]
      settings_q.spi_from_index <= `RST_SPI_SRC; // [RL8]
      settings_q.base_value <= 6'h00;
      settings_q.fb_ref_battery <= `RST_FB_REF; // [RL5]
      settings_q.auto_diag_on <= `RST_AUTO_DIAG;
      settings_q.adc_mode <= 4'h0; // [RL10]
      settings_q.arith_mode <= `RST_ARITH_MODE; // [RL15]
    end else begin
      if (do_slab) begin
        settings_q.base_from_index <= iw[0]; // [RL4]
      end
      if (do_slsa) begin
        settings_q.spi_from_index <= iw[0]; // [RL8]
      end
      if (do_stab) begin
        settings_q.base_value <= iw[5:0]; // [RL9]
      end
      // Missing rights leave everything as it was
      if (do_slfbk && drive_ok) begin // [RL7] [RL16]
        settings_q.fb_ref_battery <= iw[2]; // [RL5]
        if (iw[1:0] == `DIAG_OFF) begin
          settings_q.auto_diag_on <= 1'b0; // [RL6]
        end else if (iw[1:0] == `DIAG_ON) begin
          settings_q.auto_diag_on <= 1'b1; // [RL6]
        end
      end
      if (do_stadc && cur_ok) begin // [RL12] [RL16]
        settings_q.adc_mode[block_num] <= iw[2]; // [RL10]
      end
      if (do_stal) begin
        settings_q.arith_mode <= iw[1:0]; // [RL13]
      end
    end
  end

  // Completion, overflow capture and shift flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_q <= '0;
      done_q <= 1'b0;
      arith_ovf_q <= 1'b0;
    end else begin
      done_q <= (issue && !do_shrsi && instr.valid) || state_q == st_finish; // [RL16]
      arith_ovf_q <= arith_overflow_in; // [RL14]
      if (state_q == st_finish) begin
        cond_q.shift_out_flag <= sb_acc_q; // [RL3]
        cond_q.shift_overflow_flag <= mo_acc_q; // [RL3]
      end
    end
  end

  // Output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      shift_result <= '0;
      settings <= '0;
      cond_flags <= '0;
      saturate_enable <= 1'b0;
      alu_index_value_mux <= '0;
    end else begin
      instr_ready <= state_q == st_idle && !do_shrsi;
      instr_done <= done_q;
      shift_result <= work_q;
      settings <= settings_q;
      cond_flags <= cond_q;
      // Clamp only in saturating modes; overflow is not flagged on any output
      saturate_enable <= settings_q.arith_mode[`ARITH_SAT_BIT]; // [RL14]
      alu_index_value_mux <= settings_q.base_from_index ? index_reg_q : {{(DATA_W - 6){1'b0}}, settings_q.base_value};
    end
  end

  // Overflow seen by the ALU is registered but drives no output
  wire logic unused_ok = arith_ovf_q ^ (|alu_reg_select) ^ pwdata[31];
endmodule
`default_nettype wire

// File: testbench/mode_select_sva.sv
// Purpose: Concurrent checks on the mode select decoder ports
// Assumes: One clock domain, async active-low reset
// Notes: Shift timing tracked by a small counter beside the properties
`include "mode_select_consts.svh"
`default_nettype none
module mode_select_sva #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus answer
  input wire logic pready,
  // Instruction issue
  input wire mode_select_pkg::instr_type instr,
  input wire logic [DATA_W-1:0] alu_operand,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic [DATA_W-1:0] shift_result,
  // Settings and flags
  input wire mode_select_pkg::settings_type settings,
  input wire mode_select_pkg::cond_type cond_flags,
  input wire logic saturate_enable,
  input wire logic [DATA_W-1:0] alu_index_value_mux
);
  import mode_select_pkg::*;
  logic busy_q;
  logic msb_q;
  logic [4:0] cnt_q;
  logic [4:0] exp_q;
  // Issue decode
  wire logic issue = instr.valid && instr_ready;
  wire logic shift_go = issue && ((instr.word & `MSK_SHRSI) == `OPC_SHRSI);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shift timer; done is seen one edge after it is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      msb_q <= 1'b0;
      cnt_q <= 5'h0;
      exp_q <= 5'h0;
    end else if (shift_go) begin
      busy_q <= 1'b1;
      msb_q <= alu_operand[DATA_W-1];
      cnt_q <= 5'h1;
      exp_q <= 5'(instr.word[6:3]) + 5'h3;
    end else if (busy_q) begin
      busy_q <= !instr_done;
      cnt_q <= cnt_q + 5'h1;
    end
  end
  // Steps of a mode instruction
  sequence mode_go_s;
    issue && !shift_go;
  endsequence
  sequence done_s;
    instr_done ##1 !instr_done;
  endsequence
  a_mode_answer: assert property (mode_go_s |-> ##2 done_s)
    else $error("mode instruction not done on time");
  a_done_single: assert property (instr_done |=> !instr_done)
    else $error("done held too long");
  a_shift_busy: assert property (shift_go |=> !instr_ready)
    else $error("ready during shift");
  a_shift_count: assert property (busy_q && instr_done |-> cnt_q == exp_q)
    else $error("shift cycle count wrong");
  a_shift_bound: assert property (busy_q |-> cnt_q <= exp_q)
    else $error("shift overran its count");
  a_sign_kept: assert property (busy_q && instr_done |-> shift_result[DATA_W-1] == msb_q)
    else $error("sign bit lost");
  a_flags_quiet: assert property ($changed(cond_flags) |-> busy_q)
    else $error("flags moved outside a shift");
  a_sat_follows: assert property ($stable(settings.arith_mode) && $stable(saturate_enable)
    |-> saturate_enable == settings.arith_mode[0])
    else $error("saturation differs from mode");
  a_base_zext: assert property ($stable(settings) && !settings.base_from_index
    |-> alu_index_value_mux == DATA_W'(settings.base_value))
    else $error("base output differs from base register");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
endmodule
bind mode_select_decoder mode_select_sva #(.DATA_W(DATA_W)) sva_u (.pclk(pclk), .presetn(presetn),
  .pready(pready), .instr(instr), .alu_operand(alu_operand), .instr_ready(instr_ready),
  .instr_done(instr_done), .shift_result(shift_result), .settings(settings), .cond_flags(cond_flags),
  .saturate_enable(saturate_enable), .alu_index_value_mux(alu_index_value_mux));
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the mode select decoder
// Assumes: Default parameters, bus answers without wait states
// Notes: Bench drives all ports itself
`include "mode_select_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mode_select_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arith_overflow_in = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, instr_ready, instr_done, saturate_enable;
  instr_type instr = '0;
  logic [2:0] alu_reg_select = 3'h0;
  logic [15:0] alu_operand = 16'h0, shift_result, alu_index_value_mux;
  settings_type settings;
  cond_type cond_flags;
  int mismatches = 0, checks = 0, cycles = 0, lat;
  mode_select_decoder dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr, .alu_reg_select, .alu_operand, .instr_ready, .instr_done, .shift_result,
    .arith_overflow_in, .settings, .cond_flags, .saturate_enable, .alu_index_value_mux);
  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard, well above the expected run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycle; pready, data and error taken at the same rising edge
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one word; lat is the edge count until done shows
  task automatic exe(input logic [15:0] w, input logic [15:0] opd);
    while (instr_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    instr <= '{valid: 1'b1, word: w};
    alu_operand <= opd;
    @(posedge pclk);
    instr.valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge pclk);
      lat++;
    end while (instr_done !== 1'b1);
    repeat (2) @(negedge pclk);
  endtask
  task automatic t_reset();
    chk({30'h0, settings.arith_mode}, 32'h2);
    chk({31'h0, saturate_enable}, 32'h0);
    chk({28'h0, settings.base_from_index, settings.spi_from_index, settings.fb_ref_battery,
      settings.auto_diag_on}, 32'h0);
    chk({28'h0, settings.adc_mode}, 32'h0);
  endtask
  task automatic t_shift();
    logic [15:0] ops [3] = '{16'h8001, 16'h7ff0, 16'hc3a5};
    int ns [3] = '{1, 4, 15};
    for (int i = 0; i < 3; i++) begin
      exe(`OPC_SHRSI | 16'(ns[i] << 3), ops[i]);
      chk(32'(lat), 32'(ns[i] + 3));
      chk({16'h0, shift_result}, {16'h0, 16'($signed(ops[i]) >>> ns[i])});
      chk({30'h0, cond_flags}, {30'h0, ops[i][ns[i]-1], |(ops[i] & 16'((1 << ns[i]) - 1))});
    end
  endtask
  task automatic t_modes();
    apb(1'b1, `IDX_CORE_SETUP, 32'h1234);
    exe(`OPC_STAB | 16'h3f, 16'h0);
    chk({16'h0, alu_index_value_mux}, 32'h3f);
    exe(`OPC_SLAB | 16'h1, 16'h0);
    chk({16'h0, alu_index_value_mux}, 32'h1234);
    exe(`OPC_SLAB, 16'h0);
    chk({16'h0, alu_index_value_mux}, 32'h3f);
    exe(`OPC_SLSA | 16'h1, 16'h0);
    chk({31'h0, settings.spi_from_index}, 32'h1);
    exe(`OPC_SLSA, 16'h0);
    chk({31'h0, settings.spi_from_index}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      exe(`OPC_STAL | 16'(m), 16'h0);
      chk({30'h0, settings.arith_mode}, 32'(m));
      chk({31'h0, saturate_enable}, 32'(m & 1));
    end
  endtask
  task automatic t_rights();
    int fc [5] = '{7, 0, 1, 6, 4};
    int fe [5] = '{3, 1, 1, 2, 2};
    for (int r = 0; r < 4; r++) apb(1'b1, `IDX_DRIVE_A + 12'(r), 32'h0);
    exe(`OPC_SLFBK | 16'h7, 16'h0);
    chk({30'h0, settings.fb_ref_battery, settings.auto_diag_on}, 32'h0);
    chk(32'(lat), 32'h2);
    for (int r = 0; r < 4; r++) apb(1'b1, `IDX_DRIVE_A + 12'(r), 32'hffff);
    apb(1'b0, `IDX_DRIVE_D, 32'h0);
    chk(rd, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      exe(`OPC_SLFBK | 16'(fc[i]), 16'h0);
      chk({30'h0, settings.fb_ref_battery, settings.auto_diag_on}, 32'(fe[i]));
    end
    exe(`OPC_STADC | 16'h4, 16'h0);
    chk({28'h0, settings.adc_mode}, 32'h0);
    apb(1'b1, `IDX_CUR_FIRST, 32'hffff);
    apb(1'b1, `IDX_CUR_SECOND, 32'hffff);
    for (int t = 0; t < 4; t++) begin
      exe(`OPC_STADC | 16'h4 | 16'(t), 16'h0);
      chk(32'($countones(settings.adc_mode)), 32'(t + 1));
    end
    exe(`OPC_STADC | 16'h1, 16'h0);
    chk(32'($countones(settings.adc_mode)), 32'h3);
    apb(1'b0, 12'h1ff, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    t_reset();
    t_shift();
    t_modes();
    t_rights();
    stop_test();
  end
endmodule
`default_nettype wire
